// ### logic/branch_trace_pkg.sv
// Package of constants for the branch trace recorder
package branch_trace_pkg;
   // Stack geometry
   localparam int stack_depth = 16;
   localparam int ptr_width = 4;
   localparam int addr_width = 48;
   // Capability field
   localparam int cap_width = 6;
   localparam logic [5:0] record_format = 6'h04;
   // Source record field positions
   localparam int addr_msb = 47;
   localparam int sext_lsb = 48;
   localparam int sext_msb = 60;
   localparam int abort_bit = 61;
   localparam int in_txn_bit = 62;
   localparam int mispredict_flag_bit = 63;
   // Control register field positions
   localparam int record_enable_bit = 0;
   localparam int step_on_branches_bit = 1;
   localparam int trace_message_bit = 2;
   localparam int buffer_store_bit = 3;
   localparam int buffer_irq_bit = 4;
   localparam int skip_ring0_bit = 5;
   localparam int skip_user_bit = 6;
   localparam int ctrl_width = 7;
   localparam logic [6:0] ctrl_reset = 7'h00;
   // Identification feature flag positions
   localparam int store_feature_bit = 21;
   localparam int priv_store_feature_bit = 4;
   // Register selectors on the register port
   localparam logic [1:0] sel_source = 2'h0;
   localparam logic [1:0] sel_dest = 2'h1;
   localparam logic [1:0] sel_top = 2'h2;
   localparam logic [1:0] sel_ctrl = 2'h3;
   // Trace queue
   localparam int fifo_depth = 16;
   localparam int msg_width = 96;
endpackage : branch_trace_pkg

// ### logic/branch_trace_recorder.sv
// Branch record stack, debug control register and trace message queue
// ****************************************************************
// Operation
// - Enhanced variant holds sixteen source/destination record pairs.
// - Six-bit capability field reads 04h for the flagged record format.
// - Source record bits 47:0 hold the branch instruction address.
// - Source bits 60:48 copy address bit 47.
// - Bit 61 marks a transaction abort entry.
// - Bit 62 marks an entry made inside a transaction.
// - Bit 63 set on misprediction, clear when predicted.
// - Records form a circular stack of sixteen pairs.
// - Four-bit top pointer selects the newest record.
// - While bit 0 set, every branch, interrupt, exception is recorded.
// - Debug exception clears the record enable, freezing the stack.
// - Bit 1 makes the trap flag step on taken branches.
// - Bit 2 sends each record on the system bus as a message.
// - Bit 3 logs messages into the memory trace buffer.
// - Bit 4 raises interrupt on full buffer, else logging wraps.
// - Bit 5 skips messages produced at privilege zero.
// - Bit 6 skips messages produced at other privilege levels.
// - Identification bit 21 advertises the memory trace store.
// - Identification bit 4 advertises privilege-qualified storing.
// - Pointer increments before each write and wraps to zero.
// - Records and top pointer are read-only to software.
// - Destination holds branch target or first handler address.
// - Branch raising a trap stores branch record, then exception.
// ****************************************************************
`timescale 1ns/1ps

// ****************************************************************
// Trace message queue
// ****************************************************************
module trace_fifo #(
   parameter int width = 8,
   parameter int depth = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   localparam int aw = $clog2(depth);
   typedef struct packed {
      logic [depth-1:0][width-1:0] mem;
      logic [aw-1:0] wr;
      logic [aw-1:0] rd;
      logic [aw:0] count;
   } fifo_s;
   fifo_s state;
   fifo_s next_state;
   logic push;
   logic pop;

   assign in_ready = (state.count != (aw+1)'(depth));
   assign out_valid = (state.count != '0);
   assign out_data = state.mem[state.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_state = state;
      if (push) begin
         next_state.mem[state.wr] = in_data;
         next_state.wr = state.wr + 1'b1;
      end
      if (pop) begin
         next_state.rd = state.rd + 1'b1;
      end
      next_state.count = state.count + (aw+1)'(push) - (aw+1)'(pop);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule : trace_fifo

// ****************************************************************
// Recorder top
// ****************************************************************
module branch_trace_recorder (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Retirement events
   input wire logic evt_valid,
   input wire logic [branch_trace_pkg::addr_width-1:0] evt_source,
   input wire logic [branch_trace_pkg::addr_width-1:0] evt_dest,
   input wire logic evt_abort,
   input wire logic evt_in_txn,
   input wire logic evt_mispredict,
   input wire logic evt_ring0,
   input wire logic evt_trap_valid,
   input wire logic [branch_trace_pkg::addr_width-1:0] evt_trap_dest,
   input wire logic debug_exception,
   output logic evt_ready,
   // Register port
   input wire logic reg_wr,
   input wire logic [1:0] reg_sel,
   input wire logic [3:0] reg_index,
   input wire logic [63:0] reg_wdata,
   input wire logic reg_ring0,
   input wire logic reg_real_mode,
   output logic [63:0] reg_rdata,
   // Capability and identification
   output logic [branch_trace_pkg::cap_width-1:0] perf_capability_field,
   output logic store_feature,
   output logic priv_store_feature,
   // Trap and buffer status
   input wire logic trap_flag,
   input wire logic buffer_full,
   output logic step_on_branches,
   output logic buffer_store_enable,
   output logic buffer_full_irq,
   // Bus trace message stream
   output logic msg_valid,
   input wire logic msg_ready,
   output logic [branch_trace_pkg::msg_width-1:0] msg_data
);
   import branch_trace_pkg::*;

   typedef struct packed {
      logic [stack_depth-1:0][63:0] source_record;
      logic [stack_depth-1:0][addr_width-1:0] destination_record;
      logic [ptr_width-1:0] stack_top_pointer;
      logic [ctrl_width-1:0] ctrl;
      logic pend_trap;
      logic trap_logged;
      logic [addr_width-1:0] pend_src;
      logic [addr_width-1:0] pend_dst;
      logic pend_ring0;
      logic [63:0] rdata;
      logic irq;
      logic step;
   } rec_s;
   rec_s state;
   rec_s next_state;

   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [msg_width-1:0] fifo_in_data;

   // Source record word with sign extension and flags
   function automatic logic [63:0] make_source(
      input logic [addr_width-1:0] addr,
      input logic abort,
      input logic in_txn,
      input logic mispredict_flag
   );
      logic [63:0] w;
      w = '0;
      w[addr_msb:0] = addr;
      w[sext_msb:sext_lsb] = {13{addr[addr_msb]}};
      w[abort_bit] = abort;
      w[in_txn_bit] = in_txn;
      w[mispredict_flag_bit] = mispredict_flag;
      return w;
   endfunction : make_source

   // Privilege filter for messages
   function automatic logic msg_allowed(
      input logic [ctrl_width-1:0] c,
      input logic ring0
   );
      return ring0 ? !c[skip_ring0_bit] : !c[skip_user_bit];
   endfunction : msg_allowed

   logic take_evt;
   logic trap_slot;
   logic want_msg;
   logic [ptr_width-1:0] ptr_inc;

   // Second record of a branch-trap pair uses the slot after the branch
   assign trap_slot = state.pend_trap;
   assign want_msg = (state.ctrl[trace_message_bit]
      || state.ctrl[buffer_store_bit]);
   // Stall new events while the trap record waits or the queue is full
   assign evt_ready = !state.pend_trap && fifo_in_ready;
   assign take_evt = evt_valid && evt_ready;
   assign ptr_inc = state.stack_top_pointer + 1'b1;

   always_comb begin
      next_state = state;
      fifo_in_valid = 1'b0;
      fifo_in_data = '0;
      if (trap_slot) begin
         // Exception record follows its branch record, written only once
         // even while its message waits for room in the queue
         if (state.ctrl[record_enable_bit] && !state.trap_logged) begin
            next_state.stack_top_pointer = ptr_inc;
            next_state.source_record[ptr_inc] =
               make_source(state.pend_src, 1'b0, 1'b0, 1'b0);
            next_state.destination_record[ptr_inc] = state.pend_dst;
         end
         if (want_msg && msg_allowed(state.ctrl, state.pend_ring0)) begin
            fifo_in_valid = 1'b1;
            fifo_in_data = {state.pend_src, state.pend_dst};
         end
         next_state.pend_trap = !fifo_in_ready && fifo_in_valid;
         next_state.trap_logged = next_state.pend_trap;
      end else if (take_evt) begin
         if (state.ctrl[record_enable_bit]) begin
            // Only the slot past the top changes; older pairs stay
            next_state.stack_top_pointer = ptr_inc;
            next_state.source_record[ptr_inc] = make_source(evt_source,
               evt_abort, evt_in_txn, evt_mispredict);
            next_state.destination_record[ptr_inc] = evt_dest;
         end
         if (want_msg && msg_allowed(state.ctrl, evt_ring0)) begin
            fifo_in_valid = 1'b1;
            fifo_in_data = {evt_source, evt_dest};
         end
         if (evt_trap_valid) begin
            next_state.pend_trap = 1'b1;
            next_state.pend_src = evt_source;
            next_state.pend_dst = evt_trap_dest;
            next_state.pend_ring0 = 1'b1;
         end
      end
      // Only the control register accepts writes
      if (reg_wr && reg_sel == sel_ctrl
            && (reg_ring0 || reg_real_mode)) begin
         next_state.ctrl = reg_wdata[ctrl_width-1:0];
      end
      if (debug_exception) begin
         next_state.ctrl[record_enable_bit] = 1'b0;
      end
      case (reg_sel)
         sel_source: next_state.rdata = state.source_record[reg_index];
         sel_dest: next_state.rdata =
            {16'h0000, state.destination_record[reg_index]};
         sel_top: next_state.rdata = {60'h0, state.stack_top_pointer};
         sel_ctrl: next_state.rdata = {57'h0, state.ctrl};
         default: next_state.rdata = '0;
      endcase
      next_state.irq = state.ctrl[buffer_store_bit]
         && state.ctrl[buffer_irq_bit] && buffer_full;
      next_state.step = state.ctrl[step_on_branches_bit] && trap_flag;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   trace_fifo #(
      .width(msg_width),
      .depth(fifo_depth)
   ) queue (
      .clk(clk),
      .rst(rst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(msg_valid),
      .out_ready(msg_ready),
      .out_data(msg_data)
   );

   assign reg_rdata = state.rdata;
   assign perf_capability_field = record_format;
   assign store_feature = 1'b1;
   assign priv_store_feature = 1'b1;
   assign step_on_branches = state.step;
   assign buffer_store_enable = state.ctrl[buffer_store_bit];
   assign buffer_full_irq = state.irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ptr_advance: assert property (take_evt && state.ctrl[0]
      && !debug_exception |=> state.stack_top_pointer
      == $past(state.stack_top_pointer) + 4'h1)
      else $error("top pointer did not advance");
   a_ptr_frozen: assert property (!state.ctrl[0] && !debug_exception
      && !reg_wr |=> $stable(state.stack_top_pointer))
      else $error("pointer moved while disabled");
   a_debug_clear: assert property (debug_exception |=> !state.ctrl[0])
      else $error("record enable not cleared");
   a_address_sign_extension: assert property (take_evt && state.ctrl[0] |=>
      state.source_record[state.stack_top_pointer][sext_msb:sext_lsb]
      == {13{state.source_record[state.stack_top_pointer][addr_msb]}})
      else $error("sign extension wrong");
   a_mispredict_flag_bit: assert property (take_evt && state.ctrl[0] |=>
      state.source_record[state.stack_top_pointer][63]
      == $past(evt_mispredict))
      else $error("mispredict flag wrong");
   a_dest_store: assert property (take_evt && state.ctrl[0] |=>
      state.destination_record[state.stack_top_pointer] == $past(evt_dest))
      else $error("destination wrong");
   a_trap_pair: assert property (take_evt && evt_trap_valid
      |=> state.pend_trap ##1 !state.pend_trap || !fifo_in_ready)
      else $error("trap record not stored");
   a_write_guard: assert property (reg_wr && reg_sel == sel_ctrl
      && !reg_ring0 && !reg_real_mode && !debug_exception
      |=> $stable(state.ctrl))
      else $error("unprivileged write took effect");
   a_skip_ring0: assert property (take_evt && evt_ring0
      && state.ctrl[5] |-> !fifo_in_valid)
      else $error("ring 0 message not skipped");
   a_cap_field: assert property (perf_capability_field == 6'h04)
      else $error("capability field wrong");

   // ****************************************************************
   // Pairing, privilege, flag, wrap and queue checks
   // ****************************************************************
   a_trap_twice: assert property (take_evt && evt_trap_valid
      && state.ctrl[record_enable_bit] && !reg_wr && !debug_exception
      |-> ##2 state.stack_top_pointer
      == $past(state.stack_top_pointer, 2) + 4'h2)
      else $error("branch and exception records not paired");
   a_trap_once: assert property (state.pend_trap && state.trap_logged
      |=> $stable(state.stack_top_pointer))
      else $error("exception record written twice");
   a_txn_flags: assert property (take_evt
      && state.ctrl[record_enable_bit] |=>
      state.source_record[state.stack_top_pointer][in_txn_bit:abort_bit]
      == $past({evt_in_txn, evt_abort}))
      else $error("transaction flags wrong");
   a_wrap_zero: assert property (take_evt
      && state.ctrl[record_enable_bit] && state.stack_top_pointer == 4'hf
      |=> state.stack_top_pointer == 4'h0)
      else $error("top pointer did not wrap");

   a_ctrl_write: assert property (reg_wr && reg_sel == sel_ctrl
      && (reg_ring0 || reg_real_mode) && !debug_exception
      |=> state.ctrl == $past(reg_wdata[ctrl_width-1:0]))
      else $error("privileged control write lost");
   a_records_ro: assert property (reg_wr && reg_sel != sel_ctrl
      && !take_evt && !state.pend_trap
      |=> $stable(state.stack_top_pointer) && $stable(state.source_record)
      && $stable(state.destination_record))
      else $error("record registers took a write");
   a_irq_flag: assert property (state.ctrl[buffer_store_bit]
      && state.ctrl[buffer_irq_bit] && buffer_full |=> buffer_full_irq)
      else $error("buffer full interrupt missing");
   a_step_flag: assert property (state.ctrl[step_on_branches_bit]
      && trap_flag |=> step_on_branches)
      else $error("branch stepping not enabled");

   a_skip_user: assert property (take_evt && !evt_ring0
      && state.ctrl[skip_user_bit] |-> !fifo_in_valid)
      else $error("user message not skipped");
   a_msg_sent: assert property (take_evt && !evt_ring0
      && state.ctrl[trace_message_bit] && !state.ctrl[skip_user_bit]
      |-> fifo_in_valid)
      else $error("trace message not queued");
   a_queue_hold: assert property (msg_valid && !msg_ready
      |=> msg_valid && $stable(msg_data))
      else $error("held message dropped or changed");

   // ****************************************************************
   // Coverage of the main scenarios
   // ****************************************************************
   c_record: cover property (take_evt && state.ctrl[0]);
   c_wrap: cover property (take_evt && state.stack_top_pointer == 4'hf);
   c_trap: cover property (take_evt && evt_trap_valid);
   c_full: cover property (!fifo_in_ready);
   c_skip: cover property (take_evt && want_msg && !fifo_in_valid);
endmodule : branch_trace_recorder

// ### dv/msg_sink.sv
// System bus model that accepts trace messages and keeps them in order
`timescale 1ns/1ps
module msg_sink (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Stream
   input wire logic stall,
   input wire logic msg_valid,
   output logic msg_ready,
   input wire logic [branch_trace_pkg::msg_width-1:0] msg_data
);
   import branch_trace_pkg::*;
   logic [msg_width-1:0] q[$];
   assign msg_ready = !stall;
   always @(posedge clk) begin
      if (!rst && msg_valid && msg_ready) q.push_back(msg_data);
   end
endmodule : msg_sink

// ### dv/branch_trace_recorder_tb.sv
// Self-checking bench of the branch trace recorder
`timescale 1ns/1ps
`define check(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   failures++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module branch_trace_recorder_tb;
   import branch_trace_pkg::*;
   logic clk = 0, rst = 1, ev_v = 0, ab = 0, tx = 0, mp = 0, r0 = 0;
   logic trv = 0, dbg = 0, rdy, wr = 0, wr0 = 0, wrm = 0, tf = 0, bf = 0;
   logic stall = 0, stp, bse, irq, mv, mr, sf, psf;
   logic [47:0] src = 0, dst = 0, tdst = 0;
   logic [1:0] sel = 0;
   logic [3:0] idx = 0;
   logic [63:0] wd = 0, rd, v;
   logic [5:0] cap;
   logic [95:0] md;
   int failures = 0, compares = 0, n;
   branch_trace_recorder DUT (.clk(clk), .rst(rst), .evt_valid(ev_v),
      .evt_source(src), .evt_dest(dst), .evt_abort(ab), .evt_in_txn(tx),
      .evt_mispredict(mp), .evt_ring0(r0), .evt_trap_valid(trv),
      .evt_trap_dest(tdst), .debug_exception(dbg), .evt_ready(rdy),
      .reg_wr(wr), .reg_sel(sel), .reg_index(idx), .reg_wdata(wd),
      .reg_ring0(wr0), .reg_real_mode(wrm), .reg_rdata(rd),
      .perf_capability_field(cap), .store_feature(sf),
      .priv_store_feature(psf), .trap_flag(tf), .buffer_full(bf),
      .step_on_branches(stp), .buffer_store_enable(bse),
      .buffer_full_irq(irq), .msg_valid(mv), .msg_ready(mr),
      .msg_data(md));
   msg_sink SNK (.clk(clk), .rst(rst), .stall(stall), .msg_valid(mv),
      .msg_ready(mr), .msg_data(md));
   initial begin
      forever #10 clk = ~clk;
   end
   // ****************************************************************
   // Access tasks
   // ****************************************************************
   task automatic tick;
      @(posedge clk);
      #2;
   endtask : tick
   task automatic rreg(input logic [1:0] s, input logic [3:0] i);
      sel = s;
      idx = i;
      tick();
      v = rd;
   endtask : rreg
   task automatic wreg(input logic [1:0] s, input logic [63:0] d,
                       input logic p0, input logic rm);
      sel = s;
      wd = d;
      wr0 = p0;
      wrm = rm;
      wr = 1;
      tick();
      wr = 0;
      tick();
   endtask : wreg
   task automatic ev(input logic [47:0] s, input logic [47:0] d,
                     input logic [2:0] f, input logic p0, input logic t);
      src = s;
      dst = d;
      tdst = d ^ 48'h100;
      {ab, tx, mp} = f;
      r0 = p0;
      trv = t;
      ev_v = 1;
      for (n = 0; n < 50 && rdy !== 1'b1; n++) tick();
      `check("event ready", 1'b1, rdy)
      tick();
      ev_v = 0;
      src = ~src;
      dst = ~dst;
      tick();
   endtask : ev
   function automatic logic [63:0] srec(input logic [47:0] a,
                                        input logic [2:0] f);
      return {f[0], f[1], f[2], {13{a[47]}}, a};
   endfunction : srec
   task automatic wait_msgs(input int k);
      for (n = 0; n < 60 && SNK.q.size() < k; n++) tick();
      `check("msg count", k, SNK.q.size())
   endtask : wait_msgs
   task automatic print_verdict;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #40000;
      failures++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      #2;
      rst = 0;
      `check("cap", record_format, cap)
      `check("store feature", 1'b1, sf)
      `check("priv feature", 1'b1, psf)
      rreg(sel_ctrl, 0);
      `check("ctrl reset", 64'h0, v)
      wreg(sel_ctrl, 64'h1, 0, 0);
      rreg(sel_ctrl, 0);
      `check("ctrl user write", 64'h0, v)
      wreg(sel_ctrl, 64'h1, 0, 1);
      wreg(sel_top, 64'h5, 1, 0);
      wreg(sel_source, 64'hff, 1, 0);
      rreg(sel_ctrl, 0);
      `check("ctrl real write", 64'h1, v)
      rreg(sel_top, 0);
      `check("top ro", 4'h0, v[3:0])
      rreg(sel_source, 0);
      `check("source ro", 64'h0, v)
      ev(48'h8000_1234_5678, 48'h9abc, 3'b101, 1, 0);
      ev(48'h0000_4444_0001, 48'h5555, 3'b010, 1, 0);
      rreg(sel_top, 0);
      `check("top", 4'h2, v[3:0])
      rreg(sel_source, 1);
      `check("src1", srec(48'h8000_1234_5678, 3'b101), v)
      rreg(sel_dest, 1);
      `check("dst1", 48'h9abc, v[47:0])
      rreg(sel_source, 2);
      `check("src2", srec(48'h0000_4444_0001, 3'b010), v)
      for (int i = 0; i < 15; i++) ev(48'h100 + i, 48'h200 + i, 0, 1, 0);
      rreg(sel_top, 0);
      `check("top wrap", 4'h1, v[3:0])
      rreg(sel_source, 1);
      `check("src newest", srec(48'h10e, 0), v)
      rreg(sel_source, 2);
      `check("src kept", srec(48'h0000_4444_0001, 3'b010), v)
      rreg(sel_source, 0);
      `check("src slot0", srec(48'h10d, 0), v)
      ev(48'h7777, 48'h8888, 3'b001, 1, 1);
      rreg(sel_top, 0);
      `check("top trap", 4'h3, v[3:0])
      rreg(sel_source, 2);
      `check("branch rec", srec(48'h7777, 3'b001), v)
      rreg(sel_source, 3);
      `check("exc src", srec(48'h7777, 0), v)
      rreg(sel_dest, 3);
      `check("exc dst", 48'h8988, v[47:0])
      dbg = 1;
      tick();
      dbg = 0;
      rreg(sel_ctrl, 0);
      `check("ctrl after dbg", 64'h0, v)
      ev(48'h3333, 48'h4444, 0, 1, 0);
      rreg(sel_top, 0);
      `check("frozen", 4'h3, v[3:0])
      wreg(sel_ctrl, 64'h1a, 1, 0);
      tf = 1;
      bf = 1;
      tick();
      tick();
      `check("step", 1'b1, stp)
      `check("store en", 1'b1, bse)
      `check("irq", 1'b1, irq)
      bf = 0;
      tick();
      tick();
      `check("irq off", 1'b0, irq)
      wreg(sel_ctrl, 64'h24, 1, 0);
      ev(48'h11, 48'h22, 0, 1, 0);
      ev(48'h33, 48'h44, 0, 0, 0);
      wreg(sel_ctrl, 64'h44, 1, 0);
      ev(48'h55, 48'h66, 0, 0, 0);
      ev(48'h77, 48'h88, 0, 1, 0);
      wait_msgs(2);
      `check("msg user", {48'h33, 48'h44}, SNK.q[0])
      `check("msg ring0", {48'h77, 48'h88}, SNK.q[1])
      SNK.q.delete();
      stall = 1;
      wreg(sel_ctrl, 64'h04, 1, 0);
      for (int i = 0; i < fifo_depth; i++) ev(48'h400 + i, i, 0, 0, 0);
      tick();
      `check("queue full", 1'b0, rdy)
      `check("held", {48'h400, 48'h0}, md)
      stall = 0;
      wait_msgs(fifo_depth);
      for (int i = 0; i < fifo_depth; i++) begin
         `check("drain", {48'h400 + i, 48'h0 + i}, SNK.q[i])
      end
      tick();
      `check("empty", 1'b0, mv)
      print_verdict();
   end
endmodule : branch_trace_recorder_tb
